// ---- rtl/cactl_extdiv.sv ----
`timescale 1ns/1ps
`default_nettype none
// Divides the external oscillator; output is a level toggled every DIV/2 edges.
module cactl_extdiv #(
  parameter int DIV = 8
) (
  input wire logic ext_clk_i,
  input wire logic rst_i,
  output logic div_o
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tog_q;
  logic tog_d;
  initial begin
    if (DIV < 2 || DIV % 2 != 0) $error("DIV must be even and at least 2");
  end
  always_comb begin
    cnt_d = cnt_q + 1'b1;
    tog_d = tog_q;
    if (cnt_q == CW'(DIV / 2 - 1)) begin
      cnt_d = '0;
      tog_d = ~tog_q;
    end
  end
  always_ff @(posedge ext_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tog_q <= tog_d;
    end
  end
  assign div_o = tog_q;
endmodule : cactl_extdiv
`default_nettype wire

// ---- rtl/cactl_pkg.sv ----
package cactl_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hd8;
  localparam logic [7:0] MODE_ADDR = 8'hed;
  localparam logic [3:0] MODE_PAGE = 4'hf;
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_OVF_IE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hc7;
  localparam logic [7:0] MODE_WMASK = 8'h8f;
  localparam int SYSCLK_DIV12 = 12;
  localparam int SYSCLK_DIV4 = 4;
  localparam int EXTCLK_DIV = 8;
  typedef enum logic [2:0] {
    CACTL_TB_DIV12 = 3'h0,
    CACTL_TB_DIV4 = 3'h1,
    CACTL_TB_T0OVF = 3'h2,
    CACTL_TB_ECI = 3'h3,
    CACTL_TB_SYSCLK = 3'h4,
    CACTL_TB_EXTCLK = 3'h5
  } cactl_tb_t;
endpackage : cactl_pkg

// ---- rtl/cactl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module cactl_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_o = sync_q;
endmodule : cactl_sync
`default_nettype wire

// ---- rtl/cactl_top.sv ----
// Functional notes
// - Overflow flag sets on wrap, software clears
// - Overflow flag with enable requests interrupt
// - Run bit gates counting
// - Three module flags, set by hardware or software write
// - Enabled module flag requests interrupt
// - Control bits 5:3 read zero
// - Control at 0xd8, all pages, bit writes
// - Idle suspend freezes array during idle
// - Timebase select encodings from 3-bit field
// - Code 011 counts falling external edges
// - Code 101 uses synchronized external clock/8
// - Mode bits 6:4 read zero
// - Mode register at 0xed, page F
// - Match flag interrupts need enable and match
`timescale 1ns/1ps
`default_nettype none
module cactl_top #(
  parameter int NUM_MODULES = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_wmask_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic cpu_idle_i,
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  input wire logic ext_clk_i,
  input wire logic [NUM_MODULES-1:0] module_event_i,
  input wire logic [NUM_MODULES-1:0] module_irq_enable_i,
  input wire logic [NUM_MODULES-1:0] module_match_enable_i,
  input wire logic [NUM_MODULES-1:0] module_is_match_i,
  output logic [15:0] counter_o,
  output logic counter_tick_o,
  output logic array_active_o,
  output logic irq_o
);
  import cactl_pkg::*;

  initial begin
    if (NUM_MODULES != 3) $error("control register holds exactly three module flags");
    // The shared prescaler wraps at the slow divider and needs the fast one to divide it.
    if (SYSCLK_DIV12 % SYSCLK_DIV4 != 0) $error("divide by 12 must be a multiple of 4");
    if (SYSCLK_DIV12 > 16) $error("prescaler is four bits wide");
  end

  logic counter_overflow_flag_q;
  logic counter_overflow_flag_d;
  logic counter_run_q;
  logic counter_run_d;
  logic [2:0] module_event_flags_q;
  logic [2:0] module_event_flags_d;
  logic idle_suspend_q;
  logic idle_suspend_d;
  logic [2:0] timebase_select_q;
  logic [2:0] timebase_select_d;
  logic overflow_irq_enable_q;
  logic overflow_irq_enable_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [3:0] presc_q;
  logic [3:0] presc_d;
  logic eci_prev_q;
  logic eci_prev_d;
  logic ext_prev_q;
  logic ext_prev_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic eci_sync;
  logic ext_div;
  logic ext_sync;
  logic ctrl_sel;
  logic mode_sel;
  logic active;
  logic tick;
  logic wrap;
  logic [7:0] ctrl_wr;
  logic [7:0] mode_wr;
  logic [7:0] ctrl_rd;
  logic [7:0] mode_rd;
  logic [2:0] mod_set;

  // The count pin is asynchronous, so it passes two flip-flops before the edge detector.
  // Its edge history resets low, which cannot fake a falling edge from an idle-high pin.
  cactl_sync u_eci_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(external_count_input_i),
    .sync_o(eci_sync)
  );

  cactl_extdiv #(
    .DIV(EXTCLK_DIV)
  ) u_extdiv (
    .ext_clk_i(ext_clk_i),
    .rst_i(rst_i),
    .div_o(ext_div)
  );

  // The divided level crosses into the system domain before its edges are used.
  cactl_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(ext_div),
    .sync_o(ext_sync)
  );

  // The control register answers on every page; the mode register only on its page.
  always_comb begin
    ctrl_sel = (sfr_addr_i == CTRL_ADDR);
    mode_sel = (sfr_addr_i == MODE_ADDR) && (sfr_page_i == MODE_PAGE);
  end

  // One prescaler serves both divided timebases; it wraps at twelve, and four divides twelve.
  // It only advances while the counter runs, so a stop and restart keeps its phase.
  // Reserved codes give no tick at all rather than aliasing another source.
  always_comb begin
    active = ~(idle_suspend_q & cpu_idle_i);
    eci_prev_d = eci_sync;
    ext_prev_d = ext_sync;
    presc_d = presc_q;
    tick = 1'b0;
    case (timebase_select_q)
      CACTL_TB_DIV12: begin
        tick = (presc_q == 4'(SYSCLK_DIV12 - 1));
      end
      CACTL_TB_DIV4: begin
        tick = (presc_q[1:0] == 2'(SYSCLK_DIV4 - 1));
      end
      CACTL_TB_T0OVF: begin
        tick = timer0_overflow_i;
      end
      CACTL_TB_ECI: begin
        tick = eci_prev_q & ~eci_sync;
      end
      CACTL_TB_SYSCLK: begin
        tick = 1'b1;
      end
      CACTL_TB_EXTCLK: begin
        // Each full divided period gives one rising edge, so DIV edges per tick.
        tick = ext_sync & ~ext_prev_q;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    if (active && counter_run_q) begin
      if (presc_q == 4'(SYSCLK_DIV12 - 1)) begin
        presc_d = 4'h0;
      end else begin
        presc_d = presc_q + 4'h1;
      end
    end
    tick = tick & counter_run_q & active;
  end

  // The counter advances by one per qualified tick and wraps from the top to zero.
  always_comb begin
    count_d = count_q;
    wrap = 1'b0;
    if (tick) begin
      count_d = count_q + 16'h0001;
      wrap = (count_q == 16'hffff);
    end
  end

  // Read views and masked write images of both registers.
  // Bit-addressable writes arrive as a mask; only masked bits change.
  always_comb begin
    ctrl_rd = {counter_overflow_flag_q, counter_run_q, 3'h0, module_event_flags_q};
    mode_rd = {idle_suspend_q, 3'h0, timebase_select_q, overflow_irq_enable_q};
    ctrl_wr = (ctrl_rd & ~sfr_wmask_i) | (sfr_wdata_i & sfr_wmask_i);
    mode_wr = (mode_rd & ~sfr_wmask_i) | (sfr_wdata_i & sfr_wmask_i);
  end

  // Module events are dropped while the array is suspended, like counter ticks and prescaler steps.
  // A module that keeps its event high keeps its flag set; a software clear only holds once the event drops.
  always_comb begin
    mod_set = module_event_i & {3{active}};
  end

  // Control register: software writes land first, then hardware sets on top.
  always_comb begin
    counter_overflow_flag_d = counter_overflow_flag_q;
    counter_run_d = counter_run_q;
    module_event_flags_d = module_event_flags_q;
    if (sfr_wr_i && ctrl_sel) begin
      counter_overflow_flag_d = ctrl_wr[CTRL_OVF_BIT];
      counter_run_d = ctrl_wr[CTRL_RUN_BIT];
      module_event_flags_d = ctrl_wr[2:0];
    end
    // Hardware sets win over a software clear in the same cycle, so no event is lost.
    if (wrap) begin
      counter_overflow_flag_d = 1'b1;
    end
    module_event_flags_d = module_event_flags_d | mod_set;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_overflow_flag_q <= CTRL_RESET[CTRL_OVF_BIT];
      counter_run_q <= CTRL_RESET[CTRL_RUN_BIT];
      module_event_flags_q <= CTRL_RESET[2:0];
    end else begin
      counter_overflow_flag_q <= counter_overflow_flag_d;
      counter_run_q <= counter_run_d;
      module_event_flags_q <= module_event_flags_d;
    end
  end

  // Mode register: only software changes it, and only on its own page.
  // A write that arrives on another page falls through untouched.
  always_comb begin
    idle_suspend_d = idle_suspend_q;
    timebase_select_d = timebase_select_q;
    overflow_irq_enable_d = overflow_irq_enable_q;
    if (sfr_wr_i && mode_sel) begin
      idle_suspend_d = mode_wr[MODE_IDLE_BIT];
      timebase_select_d = mode_wr[MODE_TB_LSB +: 3];
      overflow_irq_enable_d = mode_wr[MODE_OVF_IE_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_suspend_q <= MODE_RESET[MODE_IDLE_BIT];
      timebase_select_q <= MODE_RESET[MODE_TB_LSB +: 3];
      overflow_irq_enable_q <= MODE_RESET[MODE_OVF_IE_BIT];
    end else begin
      idle_suspend_q <= idle_suspend_d;
      timebase_select_q <= timebase_select_d;
      overflow_irq_enable_q <= overflow_irq_enable_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  // Prescaler and the edge history of both external timebases.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_q <= 4'h0;
      eci_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      eci_prev_q <= eci_prev_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // Read data is registered, so a read answers one cycle after its address.
  // Unmapped addresses, and the mode address on a foreign page, read as zero.
  always_comb begin
    rdata_d = 8'h00;
    if (ctrl_sel) begin
      rdata_d = ctrl_rd;
    end else if (mode_sel) begin
      rdata_d = mode_rd;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // The request is a level that stands as long as any enabled flag stays set.
  // A match-type event only interrupts when its match enable is also set.
  always_comb begin
    irq_o = counter_overflow_flag_q & overflow_irq_enable_q;
    for (int i = 0; i < 3; i++) begin
      if (module_event_flags_q[i] && module_irq_enable_i[i] &&
          (!module_is_match_i[i] || module_match_enable_i[i])) begin
        irq_o = 1'b1;
      end
    end
  end

  // The tick and active outputs are combinational and meant for neighbouring logic only.
  assign sfr_rdata_o = rdata_q;
  assign counter_o = count_q;
  assign counter_tick_o = tick;
  assign array_active_o = active;
endmodule : cactl_top
`default_nettype wire

// ---- tb/cactl_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module cactl_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_wmask_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [15:0] counter_o,
  input wire logic counter_tick_o,
  input wire logic array_active_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence ctl_byte_wr;
    sfr_wr_i && sfr_addr_i == 8'hd8 && sfr_wmask_i == 8'hff;
  endsequence
  sequence ctl_wrap;
    counter_tick_o && counter_o == 16'hffff && sfr_addr_i == 8'hd8;
  endsequence
  AST_HOLD: assert property (!counter_tick_o |=> $stable(counter_o))
    else $error("counter moved without a tick");
  AST_INC: assert property (counter_tick_o |=> counter_o == $past(counter_o) + 16'h1)
    else $error("counter did not step by one");
  AST_WRAP: assert property (ctl_wrap ##1 sfr_addr_i == 8'hd8 |=> sfr_rdata_o[7])
    else $error("overflow flag not set on wrap");
  AST_IDLE: assert property (!array_active_o |-> !counter_tick_o)
    else $error("counter ticked while suspended");
  AST_CTL_ZERO: assert property ($past(sfr_addr_i) == 8'hd8 |-> sfr_rdata_o[5:3] == 3'h0)
    else $error("control unused bits not zero");
  AST_MODE_ZERO: assert property ($past(sfr_addr_i) == 8'hed |-> sfr_rdata_o[6:4] == 3'h0)
    else $error("mode unused bits not zero");
  AST_UNMAP: assert property (!($past(sfr_addr_i) inside {8'hd8, 8'hed}) |-> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RUN_WR: assert property (ctl_byte_wr ##1 sfr_addr_i == 8'hd8
    |=> (sfr_rdata_o & 8'h40) == ($past(sfr_wdata_i, 2) & 8'h40))
    else $error("run bit write not read back");
endmodule : cactl_top_asserts
bind cactl_top cactl_top_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wmask_i(sfr_wmask_i),
  .sfr_rdata_o(sfr_rdata_o), .counter_o(counter_o), .counter_tick_o(counter_tick_o),
  .array_active_o(array_active_o));
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cactl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, wmask = 8'h00, rdata;
  logic [3:0] page = 4'hf;
  logic wr = 1'b0, idle = 1'b0, t0 = 1'b0, external_count_input = 1'b1, xclk = 1'b0, tick, act, irq;
  logic [2:0] mev = 3'h0, mie = 3'h0, mme = 3'h0, mis = 3'h1;
  logic [15:0] cnt, c0;
  int err_total = 0, comparisons = 0, cyc = 0;
  int per[3] = '{SYSCLK_DIV12, SYSCLK_DIV4, 1};
  always #50 clk_i = ~clk_i;
  cactl_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_page_i(page),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_wmask_i(wmask), .sfr_rdata_o(rdata),
    .cpu_idle_i(idle), .timer0_overflow_i(t0), .external_count_input_i(external_count_input), .ext_clk_i(xclk),
    .module_event_i(mev), .module_irq_enable_i(mie), .module_match_enable_i(mme),
    .module_is_match_i(mis), .counter_o(cnt), .counter_tick_o(tick), .array_active_o(act),
    .irq_o(irq));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wmask = m;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : wrr
  // Read data lags the address by one edge, so it is taken a cycle later.
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk_i);
    addr = a;
    @(negedge clk_i);
    chk("rdata", {8'h00, rdata & m}, {8'h00, e});
  endtask : rc
  task automatic span(input int n, input logic [15:0] e);
    c0 = cnt;
    repeat (n) @(negedge clk_i);
    chk("count", cnt - c0, e);
  endtask : span
  task automatic evt(input logic [2:0] v);
    @(negedge clk_i);
    mev = v;
    @(negedge clk_i);
    mev = 3'h0;
  endtask : evt
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    rc(8'hd8, 8'h00, 8'hff);
    rc(8'hed, 8'h00, 8'hff);
    rc(8'h00, 8'h00, 8'hff);
    wrr(8'hed, 8'hff, 8'hff);
    rc(8'hed, 8'h8f, 8'hff);
    wrr(8'hd8, 8'hff, 8'hff);
    rc(8'hd8, 8'hc7, 8'hff);
    chk("irq", irq, 1);
    span(10, 0);
    wrr(8'hed, 8'h8c, 8'hff);
    span(10, 0);
    chk("irq", irq, 0);
    wrr(8'hd8, 8'h00, 8'hff);
    page = 4'h0;
    wrr(8'hed, 8'h01, 8'hff);
    wrr(8'hd8, 8'h40, 8'hff);
    page = 4'hf;
    rc(8'hed, 8'h8c, 8'hff);
    rc(8'hd8, 8'h40, 8'hff);
    for (int i = 0; i < 3; i++) begin
      wrr(8'hed, {4'h0, (i == 2) ? 3'h4 : 3'(i), 1'b0}, 8'hff);
      repeat (12) @(negedge clk_i);
      span(24, 16'(24 / per[i]));
    end
    chk("tick", tick, 1);
    chk("active", act, 1);
    wrr(8'hd8, 8'h00, 8'h40);
    span(10, 0);
    chk("tick", tick, 0);
    wrr(8'hd8, 8'h40, 8'h40);
    span(10, 10);
    wrr(8'hed, 8'h88, 8'hff);
    idle = 1'b1;
    span(10, 0);
    chk("active", act, 0);
    evt(3'h7);
    rc(8'hd8, 8'h40, 8'hff);
    idle = 1'b0;
    wrr(8'hed, 8'h08, 8'hff);
    idle = 1'b1;
    span(10, 10);
    idle = 1'b0;
    wrr(8'hed, 8'h04, 8'hff);
    c0 = cnt;
    repeat (5) begin
      @(negedge clk_i);
      t0 = 1'b1;
      @(negedge clk_i);
      t0 = 1'b0;
    end
    @(negedge clk_i);
    chk("count", cnt - c0, 5);
    wrr(8'hed, 8'h06, 8'hff);
    c0 = cnt;
    repeat (5) begin
      @(negedge clk_i);
      external_count_input = 1'b0;
      repeat (2) @(negedge clk_i);
      external_count_input = 1'b1;
      @(negedge clk_i);
    end
    repeat (4) @(negedge clk_i);
    chk("count", cnt - c0, 5);
    wrr(8'hed, 8'h0a, 8'hff);
    c0 = cnt;
    repeat (64) begin
      @(negedge clk_i);
      xclk = ~xclk;
    end
    repeat (4) @(negedge clk_i);
    chk("count", cnt - c0, 4);
    evt(3'h1);
    rc(8'hd8, 8'h41, 8'hff);
    chk("irq", irq, 0);
    mie = 3'h1;
    @(negedge clk_i);
    chk("irq", irq, 0);
    mme = 3'h1;
    @(negedge clk_i);
    chk("irq", irq, 1);
    wrr(8'hd8, 8'h00, 8'h01);
    chk("irq", irq, 0);
    rc(8'hd8, 8'h40, 8'hff);
    mie = 3'h2;
    evt(3'h2);
    chk("irq", irq, 1);
    repeat (4) @(negedge clk_i);
    rc(8'hd8, 8'h42, 8'hff);
    wrr(8'hd8, 8'h00, 8'h02);
    mie = 3'h0;
    wrr(8'hed, 8'h09, 8'hff);
    chk("irq", irq, 0);
    addr = 8'hd8;
    while (cnt != 16'hffff) @(negedge clk_i);
    rc(8'hd8, 8'hc0, 8'hc0);
    chk("irq", irq, 1);
    wrr(8'hd8, 8'h00, 8'h80);
    chk("irq", irq, 0);
    rc(8'hd8, 8'h40, 8'hff);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    rc(8'hd8, 8'h00, 8'hff);
    rc(8'hed, 8'h00, 8'hff);
    chk("count", cnt, 0);
    repeat (3) @(negedge clk_i);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
